// [dv/nfpi_array_model.sv]
// Array side model that answers the decoded address.
`timescale 1ns/1ns
`default_nettype none
module nfpi_array_model (
   input  wire logic [25:0] addr_in,  // Decoded address.
   output logic      [15:0] data_out, // Word stored there.
   output logic             valid_out // Word is valid.
);
   // Each word holds the inverse of its low address bits, always valid.
   assign data_out = ~addr_in[15:0];
   assign valid_out = 1'b1;
endmodule
`default_nettype wire

// [dv/nfpi_core_bench.sv]
// Self-checking bench for the flash pin interface block.
`timescale 1ns/1ns
`default_nettype none
module nfpi_core_bench;
   logic clk_in, rst_b_in, adv_n, sel_n, oe_n, we_n, wp_n, prst_n, aval, fclk;
   logic [25:0] addr, aaddr;
   logic [15:0] dq_in, dq, pdata, adata, read_config_reg;
   logic dq_oe, wt, wt_oe, act, preq;
   logic [7:0] st;
   int mismatches, tests_run, pulses;
   nfpi_array_model u_arr (.addr_in(aaddr), .data_out(adata), .valid_out(aval));
   nfpi_core DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr),
      .address_valid_n_in(adv_n), .dev_sel_n_in(sel_n), .out_en_n_in(oe_n),
      .wr_en_n_in(we_n), .wr_prot_n_in(wp_n), .flash_clk_in(fclk), .pin_rst_n_in(prst_n),
      .dq_in(dq_in), .array_data_in(adata), .array_valid_in(aval), .dq_out(dq),
      .dq_oe_out(dq_oe), .wait_out(wt), .wait_oe_out(wt_oe), .array_addr_out(aaddr),
      .active_out(act), .prog_req_out(preq), .prog_data_out(pdata), .status_out(st),
      .read_config_reg_out(read_config_reg));
   // Clock at 20 MHz.
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   // Count program pulses.
   always @(posedge clk_in) if (preq === 1'b1) pulses++;
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #5;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   // Write cycle; cf raises select before the write strobe.
   task automatic wr(input logic [25:0] a, input logic [15:0] d, input bit cf);
      addr = a;
      dq_in = d;
      sel_n = 1'b0;
      we_n = 1'b0;
      step(5);
      if (cf) sel_n = 1'b1;
      else we_n = 1'b1;
      step(1);
      sel_n = 1'b1;
      we_n = 1'b1;
      step(4);
   endtask
   task automatic rd(input logic [25:0] a, input logic [15:0] e, input logic w);
      addr = a;
      sel_n = 1'b0;
      oe_n = 1'b0;
      step(6);
      chk(dq, e);
      chk({dq_oe, wt_oe}, 16'h0003);
      chk(wt, w);
      oe_n = 1'b1;
      step(4);
      chk(dq_oe, 1'b0);
      sel_n = 1'b1;
      step(4);
      chk(act, 1'b0);
   endtask
   // Rising edges on the flash clock pin, each level held three system clocks.
   task automatic fck(input int n);
      repeat (n) begin
         fclk = 1'b1;
         step(3);
         fclk = 1'b0;
         step(3);
      end
   endtask
   // Synchronous read; the address moves to b once the first capture event has passed.
   task automatic srd(input logic [25:0] a, input logic [25:0] b, input logic [15:0] e,
                      input bit rise);
      adv_n = 1'b1;
      step(4);
      addr = a;
      sel_n = 1'b0;
      oe_n = 1'b0;
      adv_n = 1'b0;
      step(4);
      chk(wt, 1'b0);
      if (rise) begin
         adv_n = 1'b1;
         step(3);
      end else begin
         fck(1);
      end
      addr = b;
      fck(3);
      chk(wt, 1'b1);
      chk(dq, e);
      oe_n = 1'b1;
      sel_n = 1'b1;
      step(4);
      chk({dq_oe, wt_oe}, 16'h0000);
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      {mismatches, tests_run, pulses} = '0;
      // Strobe tied low for flow-through, select idle high.
      {adv_n, sel_n, oe_n, we_n, wp_n, prst_n, rst_b_in} = 7'b0111010;
      addr = '0;
      dq_in = '0;
      fclk = 1'b0;
      step(2);
      rst_b_in = 1'b1;
      step(3);
      chk(st, 8'h80);
      chk(read_config_reg, 16'h0000);
      fck(2);
      rd(26'h1234, 16'hEDCB, 1'b1);
      $display("test reset_read done");
      wr(0, 16'h0040, 0);
      wr(26'h10, 16'h5555, 0);
      chk(st, 8'h92);
      chk(pulses, 0);
      wr(0, 16'h0050, 0);
      wr(0, 16'h0060, 0);
      wr(0, 16'h00D0, 0);
      wr(0, 16'h0040, 0);
      wr(26'h10, 16'hA5A5, 1);
      chk(pulses, 1);
      chk(pdata, 16'hA5A5);
      $display("test unlock_program done");
      wr(0, 16'h0060, 0);
      wr(0, 16'h002F, 0);
      wr(0, 16'h0060, 0);
      wr(0, 16'h00D0, 0);
      wr(0, 16'h0040, 0);
      wr(0, 16'h1111, 0);
      chk({st, pulses[7:0]}, 16'h9201);
      wr(0, 16'h0050, 0);
      wp_n = 1'b1;
      wr(0, 16'h0060, 0);
      wr(0, 16'h00D0, 0);
      wr(0, 16'h0040, 0);
      wr(0, 16'h2222, 0);
      chk({st, pulses[7:0]}, 16'h8002);
      $display("test lockdown done");
      wr(26'h0400, 16'h0060, 0);
      wr(26'h0400, 16'h0003, 0);
      wr(0, 16'h0040, 0);
      wr(26'h0400000, 16'h3333, 0);
      chk({st, pulses[7:0]}, 16'h9202);
      chk(read_config_reg, 16'h0400);
      prst_n = 1'b0;
      step(4);
      wr(0, 16'h0040, 0);
      wr(0, 16'h3333, 0);
      chk({st, pulses[7:0]}, 16'h8002);
      chk(read_config_reg, 16'h0000);
      prst_n = 1'b1;
      step(3);
      rd(26'h00F0, 16'hFF0F, 1'b1);
      wr(26'h0400, 16'h0060, 0);
      wr(26'h0400, 16'h0003, 0);
      chk(read_config_reg, 16'h0400);
      wr(0, 16'h00FF, 0);
      rd(26'h00F0, 16'hFF0F, 1'b0);
      $display("test pin_reset_config done");
      wr(26'h8000, 16'h0060, 0);
      wr(26'h8000, 16'h0003, 0);
      chk(read_config_reg, 16'h8000);
      srd(26'h0123, 26'h0456, 16'hFEDC, 1'b0);
      srd(26'h0789, 26'h0ABC, 16'hF876, 1'b1);
      $display("test sync_read done");
      end_of_test();
   end
endmodule
`default_nettype wire

// [dv/nfpi_core_properties.sv]
// Concurrent checks on the flash pin interface ports.
`timescale 1ns/1ns
`default_nettype none
module nfpi_core_properties (
   input wire logic        clk_in,             // Clock.
   input wire logic        rst_b_in,           // Reset, active low.
   input wire logic        dev_sel_n_in,       // Device select.
   input wire logic        out_en_n_in,        // Output enable.
   input wire logic        wr_en_n_in,         // Write strobe.
   input wire logic        pin_rst_n_in,       // Reset pin.
   input wire logic        dq_oe_out,          // Data drive enable.
   input wire logic        wait_out,           // Wait level.
   input wire logic        wait_oe_out,        // Wait drive enable.
   input wire logic        prog_req_out,       // Program pulse.
   input wire logic [7:0]  status_out,         // Status.
   input wire logic [15:0] read_config_reg_out // Read configuration.
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // Levels held long enough to pass the two input flops.
   sequence s_desel; dev_sel_n_in [*4]; endsequence
   sequence s_oe_off; out_en_n_in [*4]; endsequence
   sequence s_pin_rst; !pin_rst_n_in [*4]; endsequence
   // Status and configuration outputs settle one cycle after the drivers.
   sequence s_pin_rst_long; !pin_rst_n_in [*5]; endsequence
   a_standby_floats: assert property (s_desel |-> !dq_oe_out && !wait_oe_out)
      else $error("outputs driven while deselected");
   a_oe_floats: assert property (s_oe_off |-> !dq_oe_out && !wait_oe_out)
      else $error("outputs driven with output enable high");
   a_wait_cause: assert property (wait_oe_out |-> !$past(dev_sel_n_in, 3) && !$past(out_en_n_in, 3))
      else $error("wait driven without select and enable");
   a_reset_refuse: assert property (s_pin_rst |-> !prog_req_out)
      else $error("program pulse during pin reset");
   a_reset_status: assert property (s_pin_rst_long |-> status_out == 8'h80 && read_config_reg_out == 16'h0000)
      else $error("status or configuration wrong in reset");
   a_prog_single: assert property (prog_req_out |=> !prog_req_out)
      else $error("program pulse longer than one cycle");
   a_async_wait: assert property (wait_oe_out && !read_config_reg_out[15] |-> wait_out == !read_config_reg_out[10])
      else $error("wait asserted in asynchronous read");
   a_dq_read_only: assert property (dq_oe_out |-> $past(wr_en_n_in, 3))
      else $error("data driven during a write");
endmodule
bind nfpi_core nfpi_core_properties u_props (.clk_in(clk_in), .rst_b_in(rst_b_in),
   .dev_sel_n_in(dev_sel_n_in), .out_en_n_in(out_en_n_in), .wr_en_n_in(wr_en_n_in),
   .pin_rst_n_in(pin_rst_n_in), .dq_oe_out(dq_oe_out), .wait_out(wait_out),
   .wait_oe_out(wait_oe_out), .prog_req_out(prog_req_out), .status_out(status_out),
   .read_config_reg_out(read_config_reg_out));
`default_nettype wire

// [hw/nfpi_core.v]
// Pin-level interface logic of a parallel flash device, sampled on one clock.
`timescale 1ns/1ns
`default_nettype none
`include "nfpi_map.vh"

// Behaviour
// - Synchronous reads latch address on strobe rise or first clock edge with strobe low.
// - Asynchronous mode holds address at strobe rise, passes it while strobe low.
// - Select low activates logic; select high means standby, data and wait float.
// - Data drivers on only while output enable low on reads; else float.
// - Reset low clears automation and refuses all writes.
// - Leaving reset enters asynchronous read-array mode.
// - Write-protect low enforces lock-down; locked-down blocks reject unlock.
// - Write-protect high bypasses lock-down so locked-down blocks can be unlocked and then programmed.
// - Writes capture address and data on first rising edge of strobe or select.
// - Sixteen-bit data bus: host writes commands, device drives register and array reads.
// - Read configuration bit ten selects the wait output polarity.
// - Synchronous reads assert wait until output data is valid.
// - Wait stays deasserted in asynchronous reads and all writes.
// - Wait driven only while select and output enable are both low.
// - Status register loads 0x80 after reset.
module nfpi_core #(
   parameter AW     = 26,               // Address width.
   parameter NBLK   = 16,               // Lockable block count.
   parameter BLKW   = 4                 // Block index width.
) (
   input  wire          clk_in,         // System clock, 20 MHz.
   input  wire          rst_b_in,       // Asynchronous reset, active low.
   input  wire [AW-1:0] addr_in,        // Address pins.
   input  wire          address_valid_n_in, // Address valid strobe, active low.
   input  wire          dev_sel_n_in,   // Device select, active low.
   input  wire          out_en_n_in,    // Output enable, active low.
   input  wire          wr_en_n_in,     // Write strobe, active low.
   input  wire          wr_prot_n_in,   // Write protect, active low.
   input  wire          flash_clk_in,   // Synchronous read clock pin.
   input  wire          pin_rst_n_in,   // Device reset pin, active low.
   input  wire [15:0]   dq_in,          // Data bus input side.
   input  wire [15:0]   array_data_in,  // Array data for the decoded address.
   input  wire          array_valid_in, // Array data is valid.
   output reg  [15:0]   dq_out,         // Data bus output side.
   output reg           dq_oe_out,      // Data bus drive enable.
   output reg           wait_out,       // Wait pin level.
   output reg           wait_oe_out,    // Wait pin drive enable.
   output reg  [AW-1:0] array_addr_out, // Address to array decode.
   output reg           active_out,     // Internal logic active, not standby.
   output reg           prog_req_out,   // One-cycle program request pulse.
   output reg  [15:0]   prog_data_out,  // Data for the program request.
   output reg  [7:0]    status_out,     // Status register contents.
   output reg  [15:0]   read_config_reg_out // Read configuration register.
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers.

localparam NS = AW + 23;
// Synchronisers reset with strobes and selects high and the reset pin low, so no false strobe edge follows reset.
localparam [NS-1:0] S_IDLE = {{AW{1'b0}}, 16'h0000, 7'h78};
reg [NS-1:0] s1_q;
reg [NS-1:0] s2_q;
wire [NS-1:0] pins = {addr_in, dq_in, address_valid_n_in, dev_sel_n_in, out_en_n_in,
                      wr_en_n_in, wr_prot_n_in, flash_clk_in, pin_rst_n_in};

// Two flops on every pin before use.
always @(posedge clk_in or negedge rst_b_in) begin
   if (!rst_b_in) begin
      s1_q <= S_IDLE;
      s2_q <= S_IDLE;
   end else begin
      s1_q <= pins;
      s2_q <= s1_q;
   end
end

wire [AW-1:0] a_s   = s2_q[NS-1:23];
wire [15:0]   d_s   = s2_q[22:7];
wire          adv_s = s2_q[6];
wire          ce_s  = s2_q[5];
wire          oe_s  = s2_q[4];
wire          we_s  = s2_q[3];
wire          wp_s  = s2_q[2];
wire          fck_s = s2_q[1];
wire          rst_s = s2_q[0];

reg           adv_p_q;
reg           ce_p_q;
reg           we_p_q;
reg           fck_p_q;
reg [AW-1:0]  lat_q;
reg [AW-1:0]  wa_q;
reg           cap_q;
reg [15:0]    wd_q;
reg [7:0]     sr_q;
reg [15:0]    rcr_q;
reg [1:0]     mode_q;
reg [1:0]     pend_q;
reg           wact_q;
reg [3:0]     lat_cnt_q;
reg [NBLK-1:0] locked_q;
reg [NBLK-1:0] ldown_q;

localparam M_ARRAY  = 2'b00;
localparam M_STATUS = 2'b01;
localparam M_CONFIG = 2'b10;
localparam P_NONE   = 2'b00;
localparam P_RCR    = 2'b01;
localparam P_PROG   = 2'b10;

wire adv_rise = adv_s & ~adv_p_q;
wire fck_rise = fck_s & ~fck_p_q;
wire sync_md  = rcr_q[`NFPI_RCR_SYNC_BIT];
wire sel      = ~ce_s & rst_s;
wire wr_end   = wact_q & ((we_s & ~we_p_q) | (ce_s & ~ce_p_q));
wire [AW-1:0] wr_addr = wa_q;

// Block index of an address.
function [BLKW-1:0] blk;
   input [AW-1:0] a;
   begin
      blk = a[AW-1:AW-BLKW];
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Address latch, write capture, command decode.

always @(posedge clk_in or negedge rst_b_in) begin
   if (!rst_b_in) begin
      adv_p_q <= 1'b1;
      ce_p_q <= 1'b1;
      we_p_q <= 1'b1;
      fck_p_q <= 1'b0;
      lat_q <= {AW{1'b0}};
      wa_q <= {AW{1'b0}};
      cap_q <= 1'b0;
      wd_q <= 16'h0000;
      sr_q <= `NFPI_SR_RESET;
      rcr_q <= `NFPI_RCR_RESET;
      mode_q <= M_ARRAY;
      pend_q <= P_NONE;
      wact_q <= 1'b0;
      locked_q <= {NBLK{1'b1}};
      ldown_q <= {NBLK{1'b0}};
      prog_req_out <= 1'b0;
      prog_data_out <= 16'h0000;
   end else begin
      adv_p_q <= adv_s;
      ce_p_q <= ce_s;
      we_p_q <= we_s;
      fck_p_q <= fck_s;
      prog_req_out <= 1'b0;
      if (!rst_s) begin
         sr_q <= `NFPI_SR_RESET;
         cap_q <= 1'b0;
         rcr_q <= `NFPI_RCR_RESET;
         mode_q <= M_ARRAY;
         pend_q <= P_NONE;
         wact_q <= 1'b0;
         locked_q <= {NBLK{1'b1}};
         ldown_q <= {NBLK{1'b0}};
      end else begin
         if (!sync_md) begin
            if (!adv_s) lat_q <= a_s;
         end else if (!cap_q && ((!adv_s && fck_rise) || adv_rise)) begin
            lat_q <= a_s;
         end
         // capture once per strobe
         // Later clock edges must not move an address that is already taken.
         if (adv_s || !sel) begin
            cap_q <= 1'b0;
         end else if (sync_md && fck_rise) begin
            cap_q <= 1'b1;
         end
         // track write window, address and data follow pins
         if (!ce_s && !we_s && oe_s) begin
            wact_q <= 1'b1;
            wd_q <= d_s;
            wa_q <= a_s;
         end
         if (wr_end) begin
            wact_q <= 1'b0;
            pend_q <= P_NONE;
            if (pend_q == P_PROG) begin
               if (locked_q[blk(wr_addr)]) begin
                  sr_q <= sr_q | `NFPI_SR_LOCKERR | `NFPI_SR_PROGERR;
               end else begin
                  prog_req_out <= 1'b1;
                  prog_data_out <= wd_q;
               end
               mode_q <= M_STATUS;
            end else if (pend_q == P_RCR && wd_q[7:0] == `NFPI_CMD_RCR_CONF) begin
               rcr_q <= wr_addr[15:0];
               mode_q <= M_ARRAY;
            end else if (pend_q == P_RCR && wd_q[7:0] == `NFPI_CMD_UNLOCK) begin
               // lock-down resists unlock only with protect low
               if (wp_s || !ldown_q[blk(wr_addr)]) locked_q[blk(wr_addr)] <= 1'b0;
               mode_q <= M_ARRAY;
            end else if (pend_q == P_RCR && wd_q[7:0] == `NFPI_CMD_LOCKDOWN) begin
               ldown_q[blk(wr_addr)] <= 1'b1;
               locked_q[blk(wr_addr)] <= 1'b1;
               mode_q <= M_ARRAY;
            end else begin
               case (wd_q[7:0])
                  `NFPI_CMD_READ:      mode_q <= M_ARRAY;
                  `NFPI_CMD_STATUS:    mode_q <= M_STATUS;
                  `NFPI_CMD_CLRSTAT:   sr_q <= `NFPI_SR_RESET;
                  `NFPI_CMD_RCR_SETUP: pend_q <= P_RCR;
                  `NFPI_CMD_PROG:      pend_q <= P_PROG;
                  default:             mode_q <= mode_q;
               endcase
            end
         end
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Read path, wait and drivers.

wire drive = sel & ~oe_s & we_s;
wire start = sel & ~adv_s & (adv_p_q | ce_p_q);
reg [15:0] rd_d;

// Read data select by mode.
always @* begin
   case (mode_q)
      M_STATUS: rd_d = {8'h00, sr_q};
      M_CONFIG: rd_d = rcr_q;
      default:  rd_d = array_data_in;
   endcase
end

always @(posedge clk_in or negedge rst_b_in) begin
   if (!rst_b_in) begin
      lat_cnt_q <= 4'h0;
      dq_out <= 16'h0000;
      dq_oe_out <= 1'b0;
      wait_out <= 1'b0;
      wait_oe_out <= 1'b0;
      array_addr_out <= {AW{1'b0}};
      active_out <= 1'b0;
      status_out <= `NFPI_SR_RESET;
      read_config_reg_out <= `NFPI_RCR_RESET;
   end else begin
      // count sync latency from clock edges
      if (!sync_md || !sel) lat_cnt_q <= 4'h0;
      else if (start) lat_cnt_q <= `NFPI_LAT_RESET;
      else if (fck_rise && lat_cnt_q != 4'h0) lat_cnt_q <= lat_cnt_q - 4'h1;
      // flow-through while strobe low in async mode
      array_addr_out <= (!sync_md && !adv_s) ? a_s : lat_q;
      active_out <= sel;
      dq_oe_out <= drive;
      dq_out <= rd_d;
      // wait driven only with select and output enable low
      wait_oe_out <= sel & ~oe_s;
      // polarity, deasserted in async and writes
      wait_out <= rcr_q[`NFPI_RCR_POL_BIT] ^~
                  (sync_md & we_s & ((lat_cnt_q != 4'h0) | ~array_valid_in));
      status_out <= sr_q;
      read_config_reg_out <= rcr_q;
   end
end

endmodule
`default_nettype wire

// [hw/nfpi_map.vh]
// Constants for the flash pin interface block.
`ifndef NFPI_MAP_VH
`define NFPI_MAP_VH
`define NFPI_SR_RESET      8'h80
`define NFPI_RCR_RESET     16'h0000
`define NFPI_RCR_POL_BIT   10
`define NFPI_RCR_SYNC_BIT  15
`define NFPI_CMD_READ      8'hFF
`define NFPI_CMD_STATUS    8'h70
`define NFPI_CMD_CLRSTAT   8'h50
`define NFPI_CMD_RCR_SETUP 8'h60
`define NFPI_CMD_RCR_CONF  8'h03
`define NFPI_CMD_UNLOCK    8'hD0
`define NFPI_CMD_LOCKDOWN  8'h2F
`define NFPI_CMD_PROG      8'h40
`define NFPI_SR_LOCKERR    8'h02
`define NFPI_SR_PROGERR    8'h10
`define NFPI_LAT_RESET     4'h3
`endif
